// ---- hw/lsc_cfg.svh ----
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

`define LSC_CLK_NS 20
`define LSC_TICK_NS 1000000
`define LSC_TICK_CYCLES (`LSC_TICK_NS / `LSC_CLK_NS)
`define LSC_TICK_W 20
`define LSC_MS_W 16

`define LSC_RATE_BLINK_MS 200
`define LSC_MGMT_PULSE_MS 400
`define LSC_ERR_PULSE_MS 100
`define LSC_TIMEOUT_BLINK_MS 250
`define LSC_RESTART_NORM_S 4
`define LSC_RESTART_TEST_S 60
`define LSC_PATTERN_S 45
`define LSC_RESTART_NORM_MS (`LSC_RESTART_NORM_S * 1000)
`define LSC_RESTART_TEST_MS (`LSC_RESTART_TEST_S * 1000)
`define LSC_PATTERN_MS (`LSC_PATTERN_S * 1000)

`define LSC_PRBS_W 9
`define LSC_PRBS_TAP 4
`define LSC_PRBS_SEED 9'h1ff
`define LSC_ERRCNT_W 16

`endif

// ---- hw/lsc_pkg.sv ----
`include "lsc_cfg.svh"

package lsc_pkg;

  // Life of one pattern session
  typedef enum logic [1:0] {
    LSC_GEN_IDLE,
    LSC_GEN_RUN,
    LSC_GEN_EXPIRED
  } lsc_gen_t;

  typedef struct packed {
    logic [`LSC_PRBS_W-1:0] gen_sh;
    logic [`LSC_PRBS_W-1:0] chk_sh;
    logic gen_bit;
    logic bit_err;
    logic [`LSC_ERRCNT_W-1:0] err_cnt;
  } lsc_prbs_t;

  typedef struct packed {
    logic [`LSC_TICK_W-1:0] tick_cnt;
    logic tick;
    logic started;
    logic rate_bad;
    lsc_gen_t gen;
    logic pat_sw_prev;
    logic [`LSC_MS_W-1:0] pat_ms;
    logic framed;
    logic link_up;
    logic [`LSC_MS_W-1:0] unfr_ms;
    logic restart;
    logic [`LSC_MS_W-1:0] blink_ms;
    logic blink;
    logic [`LSC_MS_W-1:0] err_ms;
    logic [`LSC_MS_W-1:0] mgmt_ms;
    logic line_tx_bit;
    logic line_tx_valid;
    logic line_tx_raw;
    logic term_rd;
    logic term_rd_valid;
    logic term_cts;
    logic term_cd;
    logic td_yel;
    logic rd_yel;
    logic dtr_grn;
    logic err_led;
    logic test_led;
    logic nosig_led;
  } lsc_state_t;

endpackage

// ---- hw/lsc_prbs.sv ----
`timescale 1ns/1ps
`include "lsc_cfg.svh"

module lsc_prbs (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Generator side
  input wire logic gen_step,
  input wire logic gen_inject,
  output logic gen_bit,
  // Checker side
  input wire logic chk_valid,
  input wire logic chk_bit,
  input wire logic chk_clear,
  output logic bit_err,
  output logic [`LSC_ERRCNT_W-1:0] err_cnt
);
  import lsc_pkg::*;

  lsc_prbs_t s_q, s_d;

  // Nine-stage sequence feedback, shared by generator and checker
  function automatic logic fb(input logic [`LSC_PRBS_W-1:0] sh);
    fb = sh[`LSC_PRBS_W-1] ^ sh[`LSC_PRBS_TAP];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Generator advances per slot; checker self-syncs on received bits
  always_comb begin
    s_d = s_q;
    s_d.bit_err = 1'b0;
    if (gen_step) begin
      s_d.gen_sh = {s_q.gen_sh[`LSC_PRBS_W-2:0], fb(s_q.gen_sh)};
      s_d.gen_bit = fb(s_q.gen_sh) ^ gen_inject; // Deliberate error mode
    end
    if (chk_clear) begin
      s_d.err_cnt = '0;
    end else if (chk_valid) begin
      s_d.chk_sh = {s_q.chk_sh[`LSC_PRBS_W-2:0], chk_bit};
      if (chk_bit != fb(s_q.chk_sh)) begin
        s_d.bit_err = 1'b1;
        // Saturate so a long bad run never wraps to a clean-looking count
        if (s_q.err_cnt != {`LSC_ERRCNT_W{1'b1}}) begin
          s_d.err_cnt = s_q.err_cnt + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.gen_sh <= `LSC_PRBS_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign gen_bit = s_q.gen_bit;
  assign bit_err = s_q.bit_err;
  assign err_cnt = s_q.err_cnt;

endmodule // lsc_prbs

// ---- hw/lsc_top.sv ----
`timescale 1ns/1ps
`include "lsc_cfg.svh"

module lsc_top #(
  parameter int TICK_CYCLES = `LSC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Terminal interface
  input wire logic term_td,
  input wire logic term_td_valid,
  input wire logic term_dtr,
  output logic term_rd,
  output logic term_rd_valid,
  output logic term_cts,
  output logic term_cd,
  // Line side, framer boundary
  input wire logic line_rx_bit,
  input wire logic line_rx_valid,
  input wire logic line_pkt_done,
  input wire logic line_pkt_framed,
  output logic line_tx_bit,
  output logic line_tx_valid,
  output logic line_tx_raw,
  output logic link_restart,
  // Test and event controls
  input wire logic local_loop_sw,
  input wire logic remote_loopback,
  input wire logic remote_test_req,
  input wire logic pattern_sw,
  input wire logic pattern_err_sw,
  input wire logic rate_bad,
  input wire logic mgmt_pkt_ok,
  input wire logic crc_err,
  // Front panel indicators
  output logic td_led_yellow,
  output logic td_led_green,
  output logic rd_led_yellow,
  output logic rd_led_green,
  output logic cts_led_green,
  output logic cts_led_yellow,
  output logic cd_led_green,
  output logic cd_led_yellow,
  output logic dtr_led_green,
  output logic error_indicator,
  output logic test_mode_indicator,
  output logic no_signal_indicator,
  // Status
  output logic [`LSC_ERRCNT_W-1:0] pattern_err_count
);
  import lsc_pkg::*;

  localparam logic [`LSC_TICK_W-1:0] TICK_LAST =
    `LSC_TICK_W'(TICK_CYCLES - 1);
  localparam logic [`LSC_MS_W-1:0] RATE_HALF =
    `LSC_MS_W'(`LSC_RATE_BLINK_MS / 2);
  localparam logic [`LSC_MS_W-1:0] TO_HALF =
    `LSC_MS_W'(`LSC_TIMEOUT_BLINK_MS);
  localparam logic [`LSC_MS_W-1:0] ERR_LEN = `LSC_MS_W'(`LSC_ERR_PULSE_MS);
  localparam logic [`LSC_MS_W-1:0] MGMT_LEN =
    `LSC_MS_W'(`LSC_MGMT_PULSE_MS);
  localparam logic [`LSC_MS_W-1:0] PAT_LEN = `LSC_MS_W'(`LSC_PATTERN_MS);
  localparam logic [`LSC_MS_W-1:0] RST_NORM =
    `LSC_MS_W'(`LSC_RESTART_NORM_MS);
  localparam logic [`LSC_MS_W-1:0] RST_TEST =
    `LSC_MS_W'(`LSC_RESTART_TEST_MS);

  lsc_state_t s_q, s_d;
  logic gen_bit, bit_err;
  logic [`LSC_ERRCNT_W-1:0] err_cnt;
  logic pat_on, local_pat, gen_step, chk_valid, chk_bit;

  // Count down a millisecond timer on each tick, holding at zero
  function automatic logic [`LSC_MS_W-1:0] ms_dec(
    input logic [`LSC_MS_W-1:0] v, input logic tick);
    ms_dec = (tick && v != '0) ? v - 1'b1 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pattern engine and its routing
  assign pat_on = (s_q.gen == LSC_GEN_RUN);
  // Local loop turns the pattern straight back into the checker
  assign local_pat = pat_on && local_loop_sw;
  assign gen_step = pat_on && term_td_valid;
  assign chk_valid = local_pat ? s_q.line_tx_valid :
                     (pat_on && line_rx_valid);
  assign chk_bit = local_pat ? s_q.line_tx_bit : line_rx_bit;

  lsc_prbs u_prbs (
    .clock(clock),
    .resetn(resetn),
    .gen_step(gen_step),
    .gen_inject(pattern_err_sw),
    .gen_bit(gen_bit),
    .chk_valid(chk_valid),
    .chk_bit(chk_bit),
    .chk_clear(s_q.gen == LSC_GEN_IDLE && pattern_sw),
    .bit_err(bit_err),
    .err_cnt(err_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;

    // Free-running millisecond tick
    if (s_q.tick_cnt >= TICK_LAST) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
      s_d.tick = 1'b0;
    end

    // Rate strap is looked at once, just after reset release
    s_d.started = 1'b1;
    if (!s_q.started) begin
      s_d.rate_bad = rate_bad;
    end

    // Pattern session: 45 s run, then expired until switch is normal
    s_d.pat_sw_prev = pattern_sw;
    case (s_q.gen)
      LSC_GEN_IDLE: begin
        if (pattern_sw && !s_q.pat_sw_prev) begin
          s_d.gen = LSC_GEN_RUN;
          s_d.pat_ms = PAT_LEN;
        end
      end
      LSC_GEN_RUN: begin
        s_d.pat_ms = ms_dec(s_q.pat_ms, s_q.tick);
        if (!pattern_sw) begin
          s_d.gen = LSC_GEN_IDLE;
        end else if (s_q.pat_ms == '0) begin
          s_d.gen = LSC_GEN_EXPIRED;
        end
      end
      LSC_GEN_EXPIRED: begin
        if (!pattern_sw) begin
          s_d.gen = LSC_GEN_IDLE;
        end
      end
      default: s_d.gen = LSC_GEN_IDLE;
    endcase

    // Framed reception supervises the link
    if (line_pkt_done) begin
      s_d.framed = line_pkt_framed;
      if (line_pkt_framed) begin
        s_d.link_up = 1'b1;
      end
    end
    if (line_pkt_done && line_pkt_framed) begin
      s_d.unfr_ms = '0;
    end else if (!s_q.framed && s_q.link_up && s_q.tick) begin
      // Pattern runs and remote loops stretch the limit past 45 s
      if (s_q.unfr_ms + 1'b1 >=
          ((pat_on || remote_loopback) ? RST_TEST : RST_NORM)) begin
        s_d.unfr_ms = '0;
        s_d.restart = 1'b1;
        s_d.link_up = 1'b0;
      end else begin
        s_d.unfr_ms = s_q.unfr_ms + 1'b1;
      end
    end

    // Shared blink timebase, half period depends on the cause
    if (s_q.tick) begin
      if (s_q.blink_ms == '0) begin
        s_d.blink = !s_q.blink;
        s_d.blink_ms = (s_q.gen == LSC_GEN_EXPIRED) ? TO_HALF - 1'b1
                                                    : RATE_HALF - 1'b1;
      end else begin
        s_d.blink_ms = s_q.blink_ms - 1'b1;
      end
    end

    // One error flash per event; a new event restarts it
    s_d.err_ms = ms_dec(s_q.err_ms, s_q.tick);
    if ((crc_err && !pat_on) || (bit_err && pat_on)) begin
      s_d.err_ms = ERR_LEN;
    end
    s_d.mgmt_ms = ms_dec(s_q.mgmt_ms, s_q.tick);
    if (mgmt_pkt_ok) begin
      s_d.mgmt_ms = MGMT_LEN;
    end

    // Data paths
    s_d.line_tx_raw = 1'b0;
    if (remote_loopback) begin
      s_d.line_tx_bit = line_rx_bit;
      s_d.line_tx_valid = line_rx_valid;
    end else if (pat_on) begin
      s_d.line_tx_bit = gen_bit;
      s_d.line_tx_valid = term_td_valid;
      s_d.line_tx_raw = 1'b1; // Bypasses the framer
    end else begin
      s_d.line_tx_bit = term_td;
      s_d.line_tx_valid = term_td_valid;
    end
    if (pat_on) begin
      // Unframed pattern cannot reach the terminal
      s_d.term_rd = 1'b1;
      s_d.term_rd_valid = 1'b0;
    end else if (local_loop_sw) begin
      s_d.term_rd = term_td;
      s_d.term_rd_valid = term_td_valid;
    end else begin
      s_d.term_rd = line_rx_bit;
      s_d.term_rd_valid = line_rx_valid;
    end
    s_d.term_cts = s_d.framed;
    s_d.term_cd = s_d.framed;

    // Indicators
    s_d.td_yel = term_td;
    s_d.rd_yel = s_d.term_rd;
    s_d.dtr_grn = term_dtr;
    s_d.nosig_led = !s_d.link_up;
    if (s_q.gen == LSC_GEN_EXPIRED) begin
      s_d.err_led = s_q.blink;
    end else if (s_q.rate_bad && !s_q.link_up) begin
      s_d.err_led = s_q.blink;
    end else begin
      s_d.err_led = (s_q.err_ms != '0);
    end
    // Management flash inverts the lamp so it shows in either state
    s_d.test_led = (local_loop_sw || remote_loopback || remote_test_req ||
                  s_q.gen != LSC_GEN_IDLE) ^ (s_q.mgmt_ms != '0);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign term_rd = s_q.term_rd;
  assign term_rd_valid = s_q.term_rd_valid;
  assign term_cts = s_q.term_cts;
  assign term_cd = s_q.term_cd;
  assign line_tx_bit = s_q.line_tx_bit;
  assign line_tx_valid = s_q.line_tx_valid;
  assign line_tx_raw = s_q.line_tx_raw;
  assign link_restart = s_q.restart;
  assign td_led_yellow = s_q.td_yel;
  assign td_led_green = s_q.started && !s_q.td_yel;
  assign rd_led_yellow = s_q.rd_yel;
  assign rd_led_green = s_q.started && !s_q.rd_yel;
  assign cts_led_green = s_q.term_cts;
  assign cts_led_yellow = s_q.started && !s_q.term_cts;
  assign cd_led_green = s_q.term_cd;
  assign cd_led_yellow = s_q.started && !s_q.term_cd;
  assign dtr_led_green = s_q.dtr_grn;
  assign error_indicator = s_q.err_led;
  assign test_mode_indicator = s_q.test_led;
  assign no_signal_indicator = s_q.nosig_led;
  assign pattern_err_count = err_cnt;

endmodule // lsc_top

// ---- testbench/lsc_far_end.sv ----
`timescale 1ns/1ps

module lsc_far_end (
  // Clock
  input wire logic clock,
  // Packet request from the bench
  input wire logic pkt_go,
  input wire logic pkt_framed,
  // Line receive side of the block
  output logic line_rx_bit,
  output logic line_rx_valid,
  output logic line_pkt_done,
  output logic line_pkt_framed
);
  logic [7:0] data = 8'ha5;
  initial begin
    {line_rx_bit, line_rx_valid, line_pkt_done, line_pkt_framed} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Eight bits then a closing strobe; between strobes the bit is inverted
  // so a stale value is never mistaken for data
  always @(posedge clock) begin
    if (pkt_go) begin
      for (int i = 0; i < 8; i++) begin
        line_rx_bit <= data[i];
        line_rx_valid <= 1'b1;
        @(posedge clock);
        line_rx_valid <= 1'b0;
        line_rx_bit <= ~data[i];
        @(posedge clock);
      end
      line_pkt_framed <= pkt_framed;
      line_pkt_done <= 1'b1;
      @(posedge clock);
      line_pkt_done <= 1'b0;
      line_pkt_framed <= ~pkt_framed;
      data <= {data[6:0], data[7]};
    end
  end
endmodule // lsc_far_end

// ---- testbench/lsc_props.sv ----
`timescale 1ns/1ps

module lsc_props #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Terminal side
  input wire logic term_td,
  input wire logic term_td_valid,
  input wire logic term_dtr,
  input wire logic term_rd,
  input wire logic term_rd_valid,
  input wire logic term_cts,
  input wire logic term_cd,
  // Line side
  input wire logic line_rx_bit,
  input wire logic line_rx_valid,
  input wire logic line_pkt_done,
  input wire logic line_pkt_framed,
  input wire logic line_tx_bit,
  input wire logic line_tx_valid,
  input wire logic line_tx_raw,
  input wire logic link_restart,
  // Controls
  input wire logic local_loop_sw,
  input wire logic remote_loopback,
  input wire logic remote_test_req,
  input wire logic pattern_sw,
  input wire logic crc_err,
  input wire logic mgmt_pkt_ok,
  // Lamps
  input wire logic td_led_yellow,
  input wire logic td_led_green,
  input wire logic cts_led_green,
  input wire logic cd_led_green,
  input wire logic dtr_led_green,
  input wire logic error_indicator,
  input wire logic test_mode_indicator,
  input wire logic no_signal_indicator
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Lamps settle only from the third edge after reset, so gate on that
  logic [1:0] up_q;
  always_ff @(posedge clock) begin
    if (!resetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  wire logic ok = (up_q == 2'h3);
  wire logic tst = local_loop_sw | remote_loopback | remote_test_req |
    pattern_sw;

  ////////////////////////////////////////////////////////////////////////////
  property p_td;
    ok |-> td_led_yellow == $past(term_td) && td_led_green != td_led_yellow;
  endproperty
  a_td: assert property (p_td) else $error("td lamp wrong");
  property p_dtr;
    ok |-> dtr_led_green == $past(term_dtr);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr lamp wrong");
  property p_frm;
    ok && line_pkt_done |=> term_cts == $past(line_pkt_framed) &&
      term_cd == term_cts;
  endproperty
  a_frm: assert property (p_frm) else $error("cts or cd wrong");
  property p_lamp;
    ok && line_pkt_done |-> ##[1:2]
      (cts_led_green && cd_led_green) == $past(line_pkt_framed, 2);
  endproperty
  a_lamp: assert property (p_lamp) else $error("link lamps");
  property p_ns;
    link_restart |=> no_signal_indicator;
  endproperty
  a_ns: assert property (p_ns) else $error("no signal lamp off");
  property p_crc;
    ok && crc_err && term_cts && !pattern_sw && !$past(pattern_sw)
      |-> ##2 error_indicator [*8];
  endproperty
  a_crc: assert property (p_crc) else $error("no error flash");
  property p_mgmt;
    ok && mgmt_pkt_ok && !tst && !$past(tst) |-> ##2
      test_mode_indicator [*8];
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("no mgmt flash");
  property p_ll;
    ok && local_loop_sw && term_td_valid && !pattern_sw && !$past(pattern_sw)
      |=> term_rd_valid && term_rd == $past(term_td);
  endproperty
  a_ll: assert property (p_ll) else $error("local loop lost");
  property p_rl;
    ok && remote_loopback && line_rx_valid && !local_loop_sw && !pattern_sw
      && !$past(pattern_sw) |=> line_tx_valid && term_rd_valid &&
      line_tx_bit == $past(line_rx_bit);
  endproperty
  a_rl: assert property (p_rl) else $error("remote loop lost");
  property p_raw;
    line_tx_raw |-> $past(pattern_sw, 2);
  endproperty
  a_raw: assert property (p_raw) else $error("raw without run");
  c_rst: cover property (link_restart);
  c_pat: cover property (line_tx_raw ##1 !line_tx_raw);
  c_ll: cover property (local_loop_sw && term_td_valid);
endmodule // lsc_props

bind lsc_top lsc_props #(.TICK_CYCLES(TICK_CYCLES)) lsc_props_inst (.*);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "lsc_cfg.svh"

module tb_top;
  localparam int TC = 2;
  logic clock, resetn, term_td, term_td_valid, term_dtr, term_rd;
  logic term_rd_valid, term_cts, term_cd, line_rx_bit, line_rx_valid;
  logic line_pkt_done, line_pkt_framed, line_tx_bit, line_tx_valid;
  logic line_tx_raw, link_restart, local_loop_sw, remote_loopback;
  logic remote_test_req, pattern_sw, pattern_err_sw, rate_bad;
  logic mgmt_pkt_ok, crc_err, td_led_yellow, td_led_green, rd_led_yellow;
  logic rd_led_green, cts_led_green, cts_led_yellow, cd_led_green;
  logic cd_led_yellow, dtr_led_green, error_indicator, pkt_go, pkt_framed;
  logic test_mode_indicator, no_signal_indicator;
  logic [`LSC_ERRCNT_W-1:0] pattern_err_count;
  int error_cnt = 0;
  int num_checks = 0;
  int n;

  lsc_top #(.TICK_CYCLES(TC)) lsc_top_inst (.*);
  lsc_far_end lsc_far_end_inst (.*);

  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // One packet from the far end; returns transmit strobes seen meanwhile
  task automatic pkt(input logic f, output int c);
    c = 0;
    pkt_go = 1'b1;
    pkt_framed = f;
    cyc(1);
    pkt_go = 1'b0;
    repeat (20) begin
      cyc(1);
      if (line_tx_valid === 1'b1) c++;
    end
  endtask
  // Error lamp changes over k cycles
  task automatic chg(input int k, output int c);
    logic p;
    c = 0;
    p = error_indicator;
    repeat (k) begin
      cyc(1);
      if (error_indicator !== p) c++;
      p = error_indicator;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bad rate blinks until the first framed packet brings the link up
  task automatic t_link;
    chg(800, n);
    check(n >= 4, 1);
    check(no_signal_indicator, 1);
    pkt(1'b1, n);
    check({term_cts, cts_led_green, cd_led_green, no_signal_indicator},
      4'he);
    check(n, 0);
  endtask
  task automatic t_lamps;
    for (int v = 0; v < 2; v++) begin
      term_td = v[0];
      term_dtr = v[0];
      cyc(2);
      check({td_led_yellow, td_led_green, dtr_led_green},
        {v[0], ~v[0], v[0]});
    end
    pulse(crc_err);
    cyc(1);
    check(error_indicator, 1);
    cyc(250);
    check(error_indicator, 0);
    pulse(mgmt_pkt_ok);
    cyc(1);
    check(test_mode_indicator, 1);
    cyc(850);
    check(test_mode_indicator, 0);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 3; i++) begin
      {remote_test_req, remote_loopback, local_loop_sw} = 3'h1 << i;
      cyc(2);
      check(test_mode_indicator, 1);
      if (i == 0) begin
        term_td = 1'b1;
        pulse(term_td_valid);
        check({term_rd_valid, term_rd, rd_led_yellow, rd_led_green},
          4'he);
      end
      if (i == 1) begin
        pkt(1'b1, n);
        check(n, 8);
      end
      {remote_test_req, remote_loopback, local_loop_sw} = 3'h0;
      cyc(4);
    end
  endtask
  // A framed packet mid-count restarts the unframed interval
  task automatic t_restart;
    pkt(1'b0, n);
    check(term_cd, 0);
    check({cts_led_yellow, cd_led_yellow}, 2'h3);
    cyc(2000);
    pkt(1'b1, n);
    pkt(1'b0, n);
    n = 0;
    while (link_restart !== 1'b1 && n < 9000) begin
      cyc(1);
      n++;
    end
    check(n >= 7950 && n <= 8000, 1);
    cyc(1);
    check(no_signal_indicator, 1);
    pkt(1'b1, n);
  endtask
  task automatic t_pattern;
    pattern_sw = 1'b1;
    cyc(2);
    pulse(term_td_valid);
    check({line_tx_valid, line_tx_raw}, 2'h3);
    n = 0;
    while (line_tx_raw === 1'b1 && n < 92000) begin
      cyc(1);
      n++;
      if (link_restart === 1'b1) check(link_restart, 0);
    end
    check(n >= 89900 && n <= 90010, 1);
    check(pattern_err_count, 0);
    chg(1200, n);
    check(n >= 2, 1);
    pattern_sw = 1'b0;
    cyc(3);
    chg(1200, n);
    check(n, 0);
    check(error_indicator, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    rate_bad = 1'b1;
    {term_td, term_td_valid, term_dtr, local_loop_sw, remote_loopback,
      remote_test_req, pattern_sw, pattern_err_sw, mgmt_pkt_ok, crc_err,
      pkt_go, pkt_framed} = '0;
    cyc(5);
    resetn = 1'b1;
    cyc(2);
    rate_bad = 1'b0;
    t_link();
    t_lamps();
    t_modes();
    t_restart();
    t_pattern();
    finish_test();
  end
  // Hang guard well past the longest planned run
  initial begin
    repeat (130000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule // tb_top
